// file: rtl/lamc_map.svh
`ifndef LAMC_MAP_SVH
`define LAMC_MAP_SVH
// Functional notes
// [R1] The method byte is read by actuator type, and with type zero it is ignored entirely.
// [R2] Type 1: bit 0 picks a two-byte command or a three-byte command with an enable byte.
// [R3] Type 1: bit 1 sends the position as given or as 255 minus it, reversing direction.
// [R4] Type 1: bit 2 picks the lower or upper position limit as the standby exit target.
// [R5] Type 2: bit 1 reads the argument as a logical position or as a physical step count.
// [R6] Type 2: with bit 1 set, bit 0 gives the direction of the counted steps.
// [R7] Type 2: bit 2 forces drive outputs to their computed states periodically.
// [R8] Type 2: the motor is powered before every move, and bit 3 powers it down after.
// [R9] Type 2: a method bit enables repositioning when standby is entered.
// [R10] Type 2: a method bit enables repositioning when standby is left.
// [R11] Type 2: bits 7 to 6 slow the first steps of a move, larger values slower.
// [R12] A 16-bit timer routine table pointer resets to E9C6 and is offered on the TIMER_TABLE_PTR output.
// [R13] Move timer start and stop counts are in clock cycles; stopped once the count meets stop.
// [R14] Millisecond delays convert to cycles using the clock frequency divided by 65536.

// ==========================================================
// Register indices (byte address is four times the index)
`define LAMC_IDX_TYPE     8'h00
`define LAMC_IDX_LOWER    8'h01
`define LAMC_IDX_UPPER    8'h02
`define LAMC_IDX_CMD      8'h03
`define LAMC_IDX_STATUS   8'h04
`define LAMC_IDX_DELAY    8'h05
`define LAMC_IDX_METHOD   8'h0A
`define LAMC_IDX_TPTR     8'h0B
`define LAMC_IDX_START    8'h0D
`define LAMC_IDX_STOP     8'h0F
`define LAMC_IDX_FREQ     8'h11

// ==========================================================
// Reset values
`define LAMC_RST_METHOD   8'h00
`define LAMC_RST_TPTR     16'hE9C6
`define LAMC_RST_UPPER    8'hFF
`define LAMC_RST_FREQ     16'h0000

// ==========================================================
// Method byte fields
`define LAMC_B_CMDLEN     0
`define LAMC_B_INVERT     1
`define LAMC_B_EXITMAX    2
`define LAMC_B_DIR        0
`define LAMC_B_STEPMODE   1
`define LAMC_B_FORCE      2
`define LAMC_B_PWRDN      3
`define LAMC_B_RP_EXIT    4
`define LAMC_B_RP_ENTER   5
`define LAMC_F_SLOW_HI    7
`define LAMC_F_SLOW_LO    6

// ==========================================================
// Fixed values
`define LAMC_POS_FULL     8'hFF
`define LAMC_MS_DIV       16'd1000
`define LAMC_CLK_HZ       100000000
`define LAMC_STEP_US      100
`define LAMC_STEP_CYC     (`LAMC_CLK_HZ / 1000000 * `LAMC_STEP_US)
`define LAMC_FORCE_US     1000
`define LAMC_FORCE_CYC    (`LAMC_CLK_HZ / 1000000 * `LAMC_FORCE_US)
`endif

// file: rtl/lamc_pkg.sv
package lamc_pkg;
	// ==========================================================
	// Command opcodes
	typedef enum logic [1:0] {
		LAMC_OP_NONE,
		LAMC_OP_MOVE,
		LAMC_OP_ENTER,
		LAMC_OP_EXIT
	} lamc_op_t;

	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		LAMC_IDLE,
		LAMC_P_SEND,
		LAMC_S_PWRUP,
		LAMC_S_STEP,
		LAMC_S_PWRDN
	} lamc_state_t;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} lamc_drv_byte_t;

	typedef struct packed {
		logic       power;
		logic [3:0] phase;
	} lamc_stepper_out_t;
endpackage

// file: rtl/lamc_move_timer.sv
`timescale 1ns/1ps
`include "lamc_map.svh"
module lamc_move_timer (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Bus writes
	input  wire logic        wr_start,
	input  wire logic        wr_stop,
	input  wire logic [15:0] wr_data,
	// Delay request
	input  wire logic        delay_set,
	input  wire logic [15:0] delay_ms,
	input  wire logic [15:0] freq_hw,
	// State
	output logic      [15:0] start_q,
	output logic      [15:0] stop_q,
	output logic      [15:0] count_q,
	output logic             stopped
);
	// ==========================================================
	// Conversion of milliseconds to cycles
	logic [47:0] product;
	logic [47:0] cycles;
	logic [15:0] start_d;
	logic [15:0] stop_d;
	logic        running_q;
	logic        running_d;

	assign product = {delay_ms, 32'h0000_0000} >> 16;
	assign cycles  = (product * {32'h0000_0000, freq_hw}) / {32'h0000_0000, `LAMC_MS_DIV}; //[R14]
	assign stopped = !running_q;

	// ==========================================================
	// Next state
	always_comb begin
		start_d   = start_q;
		stop_d    = stop_q;
		running_d = running_q;
		if (running_q && count_q == stop_q) begin
			running_d = 1'b0; //[R13]
		end
		if (wr_start) begin
			start_d = wr_data;
		end
		if (wr_stop) begin
			stop_d    = wr_data;
			running_d = 1'b1;
		end
		if (delay_set) begin
			start_d   = count_q; //[R13]
			stop_d    = count_q + cycles[15:0];
			running_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			start_q   <= 16'h0000;
			stop_q    <= 16'h0000;
			count_q   <= 16'h0000;
			running_q <= 1'b0;
		end else begin
			start_q   <= start_d;
			stop_q    <= stop_d;
			count_q   <= count_q + 16'h0001;
			running_q <= running_d;
		end
	end
endmodule

// file: rtl/lamc_top.sv
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`include "lamc_map.svh"
module lamc_top #(
	parameter int          STEP_CYC   = `LAMC_STEP_CYC,
	parameter int          FORCE_CYC  = `LAMC_FORCE_CYC,
	parameter int          SLOW_STEPS = 4,
	parameter logic [7:0]  PIEZO_ADDR = 8'h0C,
	parameter logic [7:0]  PIEZO_EN   = 8'h01
) (
	// Clock and reset
	input  wire logic                        CLOCK,
	input  wire logic                        RESET,
	// Wishbone slave
	input  wire logic                        CYC_I,
	input  wire logic                        STB_I,
	input  wire logic                        WE_I,
	input  wire logic [31:0]                 ADR_I,
	input  wire logic [3:0]                  SEL_I,
	input  wire logic [31:0]                 DAT_I,
	output logic      [31:0]                 DAT_O,
	output logic                             ACK_O,
	// Piezo driver byte stream
	output lamc_pkg::lamc_drv_byte_t         DRV_BYTE,
	input  wire logic                        DRV_READY,
	// Stepper drive
	output lamc_pkg::lamc_stepper_out_t      STEPPER,
	// Status
	output logic      [15:0]                 TIMER_TABLE_PTR,
	output logic                             BUSY
);
	// ==========================================================
	// Bus decode
	logic [7:0]  idx;
	logic        req;
	logic        wr;
	logic        ack_q;
	logic        ack_d;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;

	assign idx   = ADR_I[9:2];
	assign req   = CYC_I && STB_I && !ack_q;
	assign wr    = req && WE_I;
	assign ACK_O = ack_q;
	assign DAT_O = rdat_q;

	// ==========================================================
	// Software registers
	logic [1:0]  type_q,   type_d;
	logic [7:0]  lower_q,  lower_d;
	logic [7:0]  upper_q,  upper_d;
	logic [7:0]  method_q, method_d;
	logic [15:0] tptr_q,   tptr_d;
	logic [15:0] delay_q,  delay_d;
	logic [15:0] freq_q,   freq_d;
	logic        cmd_wr;
	logic [15:0] wdat16;
	logic [15:0] t_start;
	logic [15:0] t_stop;
	logic [15:0] t_count;
	logic        t_stopped;
	logic        delay_set;

	assign cmd_wr = wr && idx == `LAMC_IDX_CMD && SEL_I[1:0] == 2'b11;
	assign wdat16 = DAT_I[15:0];
	assign TIMER_TABLE_PTR = tptr_q; //[R12]

	always_comb begin
		type_d   = type_q;
		lower_d  = lower_q;
		upper_d  = upper_q;
		method_d = method_q;
		tptr_d   = tptr_q;
		delay_d  = delay_q;
		freq_d   = freq_q;
		if (wr && SEL_I[0]) begin
			case (idx)
				`LAMC_IDX_TYPE: begin
					type_d = DAT_I[1:0];
				end
				`LAMC_IDX_LOWER: begin
					lower_d = DAT_I[7:0];
				end
				`LAMC_IDX_UPPER: begin
					upper_d = DAT_I[7:0];
				end
				`LAMC_IDX_METHOD: begin
					method_d = DAT_I[7:0];
				end
				default: begin
				end
			endcase
		end
		if (wr && SEL_I[1:0] == 2'b11) begin
			case (idx)
				`LAMC_IDX_TPTR: begin
					tptr_d = wdat16; //[R12]
				end
				`LAMC_IDX_DELAY: begin
					delay_d = wdat16;
				end
				`LAMC_IDX_FREQ: begin
					freq_d = wdat16; //[R14]
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			type_q   <= 2'h0;
			lower_q  <= 8'h00;
			upper_q  <= `LAMC_RST_UPPER;
			method_q <= `LAMC_RST_METHOD;
			tptr_q   <= `LAMC_RST_TPTR;
			delay_q  <= 16'h0000;
			freq_q   <= `LAMC_RST_FREQ;
		end else begin
			type_q   <= type_d;
			lower_q  <= lower_d;
			upper_q  <= upper_d;
			method_q <= method_d;
			tptr_q   <= tptr_d;
			delay_q  <= delay_d;
			freq_q   <= freq_d;
		end
	end

	// ==========================================================
	// Move timer
	lamc_move_timer u_timer (
		.clk       (CLOCK),
		.rst       (RESET),
		.wr_start  (wr && idx == `LAMC_IDX_START && SEL_I[1:0] == 2'b11),
		.wr_stop   (wr && idx == `LAMC_IDX_STOP && SEL_I[1:0] == 2'b11),
		.wr_data   (wdat16),
		.delay_set (delay_set),
		.delay_ms  (delay_d),
		.freq_hw   (freq_q),
		.start_q   (t_start),
		.stop_q    (t_stop),
		.count_q   (t_count),
		.stopped   (t_stopped)
	);

	// ==========================================================
	// Step and forcing dividers
	localparam int SW = $clog2(STEP_CYC + 1);
	localparam int FW = $clog2(FORCE_CYC + 1);
	logic [SW-1:0] sdiv_q, sdiv_d;
	logic [FW-1:0] fdiv_q, fdiv_d;
	logic          step_tick;
	logic          force_tick;

	assign step_tick  = sdiv_q == SW'(STEP_CYC - 1);
	assign force_tick = fdiv_q == FW'(FORCE_CYC - 1);

	always_comb begin
		sdiv_d = step_tick ? '0 : sdiv_q + SW'(1);
		fdiv_d = force_tick ? '0 : fdiv_q + FW'(1);
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			sdiv_q <= '0;
			fdiv_q <= '0;
		end else begin
			sdiv_q <= sdiv_d;
			fdiv_q <= fdiv_d;
		end
	end

	// ==========================================================
	// Sequencer
	lamc_pkg::lamc_state_t       st_q, st_d;
	lamc_pkg::lamc_op_t          op;
	lamc_pkg::lamc_drv_byte_t    drv_q, drv_d;
	lamc_pkg::lamc_stepper_out_t out_q, out_d;
	logic [1:0] bidx_q, bidx_d;
	logic [7:0] pbyte_q, pbyte_d;
	logic [7:0] pos_q, pos_d;
	logic [7:0] left_q, left_d;
	logic [7:0] done_q, done_d;
	logic [1:0] wait_q, wait_d;
	logic       dir_q, dir_d;
	logic [1:0] ph_q, ph_d;
	logic [7:0] arg;
	logic [7:0] target;
	logic [1:0] nbytes;
	logic [1:0] slow;
	logic [3:0] calc;
	logic [1:0] ph_next;
	logic [3:0] calc_next;

	assign op      = lamc_pkg::lamc_op_t'(DAT_I[9:8]);
	assign arg     = DAT_I[7:0];
	assign nbytes  = method_q[`LAMC_B_CMDLEN] ? 2'd3 : 2'd2; //[R2]
	assign slow    = method_q[`LAMC_F_SLOW_HI:`LAMC_F_SLOW_LO];
	assign ph_next = dir_q ? ph_q + 2'd1 : ph_q - 2'd1;
	assign BUSY    = st_q != lamc_pkg::LAMC_IDLE;
	assign DRV_BYTE = drv_q;
	assign STEPPER  = out_q;

	always_comb begin
		case (ph_q)
			2'd0: calc = 4'h9;
			2'd1: calc = 4'h3;
			2'd2: calc = 4'h6;
			default: calc = 4'hC;
		endcase
	end

	// Pattern of the index a step moves to, so forcing repeats it unchanged
	always_comb begin
		case (ph_next)
			2'd0: calc_next = 4'h9;
			2'd1: calc_next = 4'h3;
			2'd2: calc_next = 4'h6;
			default: calc_next = 4'hC;
		endcase
	end

	always_comb begin
		target = (op == lamc_pkg::LAMC_OP_MOVE) ? arg : lower_q;
		if (type_q == 2'd1 && op == lamc_pkg::LAMC_OP_EXIT) begin
			target = method_q[`LAMC_B_EXITMAX] ? upper_q : lower_q; //[R4]
		end
	end

	always_comb begin
		st_d    = st_q;
		drv_d   = drv_q;
		out_d   = out_q;
		bidx_d  = bidx_q;
		pbyte_d = pbyte_q;
		pos_d   = pos_q;
		left_d  = left_q;
		done_d  = done_q;
		wait_d  = wait_q;
		dir_d   = dir_q;
		ph_d    = ph_q;
		delay_set = wr && idx == `LAMC_IDX_DELAY && SEL_I[1:0] == 2'b11;
		if (method_q[`LAMC_B_FORCE] && type_q == 2'd2 && force_tick) begin
			out_d.phase = calc; //[R7]
		end
		case (st_q)
			lamc_pkg::LAMC_IDLE: begin
				if (cmd_wr && type_q == 2'd1 && op != lamc_pkg::LAMC_OP_NONE
				    && op != lamc_pkg::LAMC_OP_ENTER) begin
					pbyte_d = method_q[`LAMC_B_INVERT] ? `LAMC_POS_FULL - target : target; //[R3]
					bidx_d  = 2'd0;
					drv_d   = '{valid: 1'b1, data: PIEZO_ADDR};
					st_d    = lamc_pkg::LAMC_P_SEND;
				end else if (cmd_wr && type_q == 2'd2 && op != lamc_pkg::LAMC_OP_NONE) begin
					if (op == lamc_pkg::LAMC_OP_MOVE && method_q[`LAMC_B_STEPMODE]) begin
						dir_d  = method_q[`LAMC_B_DIR]; //[R6]
						left_d = arg; //[R5]
					end else begin
						dir_d  = target > pos_q; //[R5]
						left_d = (target > pos_q) ? target - pos_q : pos_q - target;
					end
					if ((op == lamc_pkg::LAMC_OP_ENTER && !method_q[`LAMC_B_RP_ENTER])
					    || (op == lamc_pkg::LAMC_OP_EXIT && !method_q[`LAMC_B_RP_EXIT])) begin
						left_d = 8'h00; //[R9] [R10]
					end
					done_d      = 8'h00;
					wait_d      = 2'd0;
					out_d.power = 1'b1; //[R8]
					st_d        = lamc_pkg::LAMC_S_PWRUP;
				end
			end
			lamc_pkg::LAMC_P_SEND: begin
				if (DRV_READY) begin
					bidx_d = bidx_q + 2'd1;
					if (bidx_q + 2'd1 == nbytes) begin
						drv_d.valid = 1'b0;
						delay_set   = 1'b1;
						st_d        = lamc_pkg::LAMC_IDLE;
					end else if (bidx_q == 2'd0 && nbytes == 2'd3) begin
						drv_d.data = PIEZO_EN; //[R2]
					end else begin
						drv_d.data = pbyte_q;
					end
				end
			end
			lamc_pkg::LAMC_S_PWRUP: begin
				if (step_tick) begin
					st_d = lamc_pkg::LAMC_S_STEP;
				end
			end
			lamc_pkg::LAMC_S_STEP: begin
				if (left_q == 8'h00) begin
					st_d = lamc_pkg::LAMC_S_PWRDN;
				end else if (step_tick) begin
					if (done_q < 8'(SLOW_STEPS) && wait_q < slow) begin
						wait_d = wait_q + 2'd1; //[R11]
					end else begin
						wait_d      = 2'd0;
						ph_d        = ph_next;
						left_d      = left_q - 8'h01;
						done_d      = (done_q == 8'hFF) ? done_q : done_q + 8'h01;
						pos_d       = dir_q ? pos_q + 8'h01 : pos_q - 8'h01;
						out_d.phase = calc_next; //[R7]
					end
				end
			end
			lamc_pkg::LAMC_S_PWRDN: begin
				if (method_q[`LAMC_B_PWRDN]) begin
					out_d.power = 1'b0; //[R8]
				end
				st_d = lamc_pkg::LAMC_IDLE;
			end
			default: begin
				st_d = lamc_pkg::LAMC_IDLE;
			end
		endcase
		if (type_q == 2'd0) begin
			st_d        = lamc_pkg::LAMC_IDLE; //[R1]
			drv_d.valid = 1'b0;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			st_q    <= lamc_pkg::LAMC_IDLE;
			drv_q   <= '0;
			out_q   <= '0;
			bidx_q  <= 2'd0;
			pbyte_q <= 8'h00;
			pos_q   <= 8'h00;
			left_q  <= 8'h00;
			done_q  <= 8'h00;
			wait_q  <= 2'd0;
			dir_q   <= 1'b0;
			ph_q    <= 2'd0;
		end else begin
			st_q    <= st_d;
			drv_q   <= drv_d;
			out_q   <= out_d;
			bidx_q  <= bidx_d;
			pbyte_q <= pbyte_d;
			pos_q   <= pos_d;
			left_q  <= left_d;
			done_q  <= done_d;
			wait_q  <= wait_d;
			dir_q   <= dir_d;
			ph_q    <= ph_d;
		end
	end

	// ==========================================================
	// Read data and acknowledge
	always_comb begin
		ack_d  = req;
		rdat_d = rdat_q;
		if (req) begin
			case (idx)
				`LAMC_IDX_TYPE:   rdat_d = {30'h0, type_q};
				`LAMC_IDX_LOWER:  rdat_d = {24'h0, lower_q};
				`LAMC_IDX_UPPER:  rdat_d = {24'h0, upper_q};
				`LAMC_IDX_STATUS: rdat_d = {14'h0, out_q.power, t_stopped, BUSY, 7'h0, pos_q};
				`LAMC_IDX_DELAY:  rdat_d = {16'h0, delay_q};
				`LAMC_IDX_METHOD: rdat_d = {24'h0, method_q};
				`LAMC_IDX_TPTR:   rdat_d = {16'h0, tptr_q};
				`LAMC_IDX_START:  rdat_d = {16'h0, t_start};
				`LAMC_IDX_STOP:   rdat_d = {16'h0, t_stop};
				`LAMC_IDX_FREQ:   rdat_d = {16'h0, freq_q};
				default:          rdat_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	logic unused;
	assign unused = &{1'b0, t_count, ADR_I[31:10], ADR_I[1:0], DAT_I[31:16], SEL_I[3:2]};
endmodule

// file: tb/lamc_top_sva.sv
`timescale 1ns/1ps
module lamc_top_sva #(
	parameter logic [7:0] PIEZO_ADDR = 8'h0C
) (
	// Clock and reset
	input wire logic                        CLOCK,
	input wire logic                        RESET,
	// Bus
	input wire logic                        CYC_I,
	input wire logic                        STB_I,
	input wire logic                        ACK_O,
	// Drive side
	input wire lamc_pkg::lamc_drv_byte_t    DRV_BYTE,
	input wire logic                        DRV_READY,
	input wire lamc_pkg::lamc_stepper_out_t STEPPER,
	// Status
	input wire logic [15:0]                 TIMER_TABLE_PTR,
	input wire logic                        BUSY
);
	// ==========================================================
	// Checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);

	a_ack_latency: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
		else $error("ack not one cycle after request");
	a_ack_single: assert property (ACK_O |=> !ACK_O)
		else $error("ack longer than one cycle");
	a_ptr_reset: assert property ($fell(RESET) |-> TIMER_TABLE_PTR == 16'hE9C6)
		else $error("table pointer reset value wrong");
	a_frame_addr: assert property ($rose(DRV_BYTE.valid) |-> DRV_BYTE.data == PIEZO_ADDR)
		else $error("frame does not open with address");
	a_byte_hold: assert property (DRV_BYTE.valid && !DRV_READY |=> $stable(DRV_BYTE))
		else $error("byte changed before accept");
	a_valid_busy: assert property (DRV_BYTE.valid |-> BUSY)
		else $error("byte offered while idle");
	a_step_power: assert property (!$stable(STEPPER.phase) |-> STEPPER.power)
		else $error("step without power");
	a_phase_legal: assert property (STEPPER.phase inside {4'h0, 4'h9, 4'h3, 4'h6, 4'hC})
		else $error("illegal phase pattern");
endmodule

bind lamc_top lamc_top_sva #(.PIEZO_ADDR(PIEZO_ADDR)) lamc_top_sva_inst (
	.CLOCK(CLOCK), .RESET(RESET), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
	.DRV_BYTE(DRV_BYTE), .DRV_READY(DRV_READY), .STEPPER(STEPPER),
	.TIMER_TABLE_PTR(TIMER_TABLE_PTR), .BUSY(BUSY));

// file: tb/lamc_piezo_model.sv
`timescale 1ns/1ps
module lamc_piezo_model (
	// Clock and reset
	input wire logic                     clk,
	input wire logic                     rst,
	// Byte link
	input wire lamc_pkg::lamc_drv_byte_t drv,
	input wire logic                     slow,
	output logic                         ready
);
	logic [1:0] cnt;
	logic [7:0] q[$];
	// ==========================================================
	// Ready pacing and byte capture
	initial begin
		cnt = 2'h0;
		ready = 1'b0;
	end
	always @(posedge clk) begin
		cnt <= cnt + 2'h1;
		ready <= !rst && (!slow || cnt == 2'h3);
		if (drv.valid && ready)
			q.push_back(drv.data);
	end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic                        clk, rst, cyc, stb, we, slow, ack, rdy, busy;
	logic [31:0]                 adr, dat, r, dat_o, rs;
	logic [15:0]                 tptr, s16;
	logic [7:0]                  lo, hi, m;
	int                          fails, n_tests, pos;
	logic [7:0]                  exq[$];
	logic [7:0]                  ri[5] = '{8'h0A, 8'h0B, 8'h0D, 8'h0F, 8'h30};
	logic [31:0]                 rv[5] = '{32'h0, 32'h0000E9C6, 32'h0, 32'h0, 32'h0};
	logic [3:0]                  pt[4] = '{4'h9, 4'h3, 4'h6, 4'hC};
	lamc_pkg::lamc_drv_byte_t    drv;
	lamc_pkg::lamc_stepper_out_t stp;

	// ==========================================================
	// Clock and instances
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	lamc_top #(.STEP_CYC(8), .FORCE_CYC(32)) lamc_top_inst (.CLOCK(clk), .RESET(rst),
		.CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat),
		.DAT_O(dat_o), .ACK_O(ack), .DRV_BYTE(drv), .DRV_READY(rdy), .STEPPER(stp),
		.TIMER_TABLE_PTR(tptr), .BUSY(busy));
	lamc_piezo_model lamc_piezo_model_inst (.clk(clk), .rst(rst), .drv(drv),
		.slow(slow), .ready(rdy));

	// ==========================================================
	// Tasks
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task wb(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {22'h0, i, 2'b00};
		dat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task wr(input logic [7:0] i, input logic [31:0] d);
		wb(1'b1, i, d);
	endtask
	task rd(input logic [7:0] i);
		wb(1'b0, i, 32'h0);
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", s, e, g);
			fails++;
		end
	endtask
	task idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000)
			fails++;
		repeat (2) @(posedge clk);
	endtask
	task pz(input logic [1:0] op, input logic [7:0] a);
		logic [7:0] t;
		t = (op == 2'h3) ? (m[2] ? hi : lo) : a;
		if (m[1])
			t = 8'hFF - t;
		exq = {8'h0C};
		if (m[0])
			exq.push_back(8'h01);
		exq.push_back(t);
		if (op == 2'h2)
			exq = {};
		lamc_piezo_model_inst.q = {};
		wr(8'h03, {22'h0, op, a});
		idle;
		chk("frame length", exq.size(), lamc_piezo_model_inst.q.size());
		foreach (exq[j])
			chk("piezo byte", exq[j], lamc_piezo_model_inst.q[j]);
	endtask
	task st(input logic [1:0] op, input logic [7:0] a, input int e);
		wr(8'h0A, {24'h0, m});
		wr(8'h03, {22'h0, op, a});
		idle;
		rd(8'h04);
		chk("position", e, r[7:0]);
		chk("phase", pt[e % 4], stp.phase);
		chk("power", !m[3], r[17]);
		chk("power pin", !m[3], stp.power);
		pos = e;
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ==========================================================
	// Watchdog
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		final_report;
	end

	// ==========================================================
	// Tests
	initial begin
		{rst, cyc, stb, we, slow} = 5'h10;
		{adr, dat, fails, n_tests} = '0;
		rs = 32'hDE75102F;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		wr(8'h30, 32'hFFFFFFFF);
		chk("table pin reset", 32'h0000E9C6, {16'h0, tptr});
		foreach (ri[i]) begin
			rd(ri[i]);
			chk("reset value", rv[i], r);
		end
		$display("test reset done");
		foreach (ri[i]) begin
			rs = lfsr(rs);
			wr(ri[i], rs);
			rd(ri[i]);
			chk("readback", i == 0 ? {24'h0, rs[7:0]} : i == 4 ? 32'h0 : {16'h0, rs[15:0]}, r);
		end
		rs = lfsr(rs);
		wr(8'h0B, rs);
		chk("table pin", {16'h0, rs[15:0]}, {16'h0, tptr});
		$display("test registers done");
		m = 8'h07;
		wr(8'h0A, {24'h0, m});
		lamc_piezo_model_inst.q = {};
		wr(8'h03, 32'h00000155);
		repeat (20) @(posedge clk);
		chk("type zero bytes", 32'h0, lamc_piezo_model_inst.q.size());
		chk("type zero busy", 32'h0, busy);
		$display("test type zero done");
		wr(8'h00, 32'h2);
		wr(8'h01, 32'h0);
		rd(8'h04);
		chk("position reset", 32'h0, r[7:0]);
		pos = 0;
		m = 8'h0B;
		st(2'h1, 8'h03, pos + 3);
		m = 8'hC4;
		st(2'h1, 8'h01, 1);
		wr(8'h01, 32'h2);
		m = 8'h20;
		st(2'h2, 8'h00, 2);
		wr(8'h01, 32'h0);
		m = 8'h00;
		st(2'h3, 8'h00, 2);
		m = 8'h18;
		st(2'h3, 8'h00, 0);
		$display("test stepper done");
		wr(8'h00, 32'h1);
		rs = lfsr(rs);
		lo = rs[7:0];
		hi = rs[15:8];
		wr(8'h01, {24'h0, lo});
		wr(8'h02, {24'h0, hi});
		for (int i = 0; i < 8; i++) begin
			m = i[7:0];
			wr(8'h0A, {24'h0, m});
			slow <= rs[i];
			rs = lfsr(rs);
			pz(2'h1, rs[7:0]);
			pz(2'h3, 8'h00);
		end
		pz(2'h2, 8'h00);
		slow <= 1'b0;
		$display("test piezo done");
		wr(8'h11, 32'h1);
		wr(8'h05, 32'h1);
		rd(8'h0D);
		s16 = r[15:0];
		rd(8'h0F);
		chk("timer span", 32'h41, {16'h0, r[15:0] - s16});
		rd(8'h04);
		chk("stopped early", 32'h0, r[16]);
		repeat (80) @(posedge clk);
		rd(8'h04);
		chk("stopped late", 32'h1, r[16]);
		$display("test timer done");
		final_report;
	end
endmodule
